//--- bench/rzw_mem_model.sv
// Memory model that takes the writer's writes.
`timescale 1ns/100ps
module rzw_mem_model (
	input wire logic               clk_i,
	input wire logic               ywr_valid_i,
	input wire rzw_pkg::rzw_addr_t ywr_addr_i,
	input wire logic [31:0]        ywr_data_i,
	input wire logic [2:0]         ywr_bytes_i,
	input wire logic               cwr_valid_i,
	input wire rzw_pkg::rzw_addr_t cwr_addr_i,
	input wire logic [31:0]        cwr_data_i
);
	import rzw_pkg::*;
	logic [31:0] ymem [rzw_addr_t];
	logic [31:0] cmem [rzw_addr_t];
	logic [2:0]  ybytes;
	int          ccnt = 0;
	// The memory takes every write at once, as there is no stall path.
	always @(posedge clk_i) begin
		if (ywr_valid_i) begin
			ymem[ywr_addr_i] = ywr_data_i;
			ybytes = ywr_bytes_i;
		end
		if (cwr_valid_i) begin
			cmem[cwr_addr_i] = cwr_data_i;
			ccnt++;
		end
	end
endmodule : rzw_mem_model

//--- bench/rzw_writer_monitor.sv
// Port checker of the resizer output writer.
`timescale 1ns/100ps
module rzw_writer_chk (
	input wire logic               clk_i,
	input wire logic               srst_i,
	input wire logic               reg_re_i,
	input wire logic [31:0]        reg_rdata_o,
	input wire logic               frame_start_i,
	input wire logic               pix_valid_i,
	input wire logic               line_end_i,
	input wire logic               ywr_valid_o,
	input wire rzw_pkg::rzw_addr_t ywr_addr_o,
	input wire logic [31:0]        ywr_data_o,
	input wire logic [2:0]         ywr_bytes_o,
	input wire logic               cwr_valid_o,
	input wire logic [2:0]         cwr_bytes_o
);
	import rzw_pkg::*;
	// ****
	// Properties
	// ****
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	property p_y_lat; pix_valid_i && !frame_start_i |=> ywr_valid_o; endproperty
	a_y_lat: assert property (p_y_lat)
		else $error("Luma write missing.");
	property p_y_cause; ywr_valid_o |-> $past(pix_valid_i && !frame_start_i); endproperty
	a_y_cause: assert property (p_y_cause)
		else $error("Luma write without pixel.");
	property p_fs_drop; frame_start_i |=> !ywr_valid_o && !cwr_valid_o; endproperty
	a_fs_drop: assert property (p_fs_drop)
		else $error("Write after frame start.");
	property p_rd_idle; !reg_re_i |=> reg_rdata_o == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("Read data without strobe.");
	property p_y_bytes; ywr_valid_o |-> ywr_bytes_o inside {3'h1, 3'h2, 3'h4}; endproperty
	a_y_bytes: assert property (p_y_bytes)
		else $error("Bad byte count.");
	property p_ycc; ywr_valid_o && ywr_bytes_o == 3'h1 |-> ywr_data_o[31:8] == 24'h0; endproperty
	a_ycc: assert property (p_ycc)
		else $error("Sample word upper bits set.");
	property p_rgb16; ywr_valid_o && ywr_bytes_o == 3'h2 |-> ywr_data_o[31:16] == 16'h0; endproperty
	a_rgb16: assert property (p_rgb16)
		else $error("Short word upper bits set.");
	property p_c_bytes; cwr_valid_o |-> cwr_bytes_o == 3'h1; endproperty
	a_c_bytes: assert property (p_c_bytes)
		else $error("Chroma byte count.");
	property p_adv;
		pix_valid_i && !line_end_i && !frame_start_i ##1 pix_valid_i && !frame_start_i
			|=> ywr_addr_o == $past(ywr_addr_o) + {29'h0, $past(ywr_bytes_o)};
	endproperty
	a_adv: assert property (p_adv)
		else $error("Address did not advance.");
endmodule : rzw_writer_chk

bind rzw_writer rzw_writer_chk rzw_writer_chk_i (.clk_i, .srst_i, .reg_re_i, .reg_rdata_o,
	.frame_start_i, .pix_valid_i, .line_end_i, .ywr_valid_o, .ywr_addr_o, .ywr_data_o,
	.ywr_bytes_o, .cwr_valid_o, .cwr_bytes_o);

//--- bench/rzw_writer_tb_top.sv
// Testbench of the resizer output writer.
`timescale 1ns/100ps
`include "rzw_defines.svh"
module rzw_writer_tb_top;
	import rzw_pkg::*;
	localparam logic [7:0] LS = `RZW_OFF_LUMA_SET;
	localparam logic [7:0] CS = `RZW_OFF_CHROMA_SET;
	logic        clk_i = 0, srst_i = 1, reg_we_i = 0, reg_re_i = 0;
	logic [7:0]  reg_addr_i = 0, pix_r_i = 0, pix_g_i = 0, pix_b_i = 0, pix_y_i = 0, cpix_c_i = 0;
	logic [31:0] reg_wdata_i = 0, reg_rdata_o, ywr_data_o, cwr_data_o;
	logic        frame_start_i = 0, pix_valid_i = 0, line_end_i = 0;
	logic        cpix_valid_i = 0, cline_end_i = 0, ywr_valid_o, cwr_valid_o, ch2_enable_o;
	rzw_addr_t   ywr_addr_o, cwr_addr_o;
	logic [2:0]  ywr_bytes_o, cwr_bytes_o;
	int          fails = 0, n_checks = 0, cyc = 0;
	rzw_writer rzw_writer_i (.clk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i,
		.reg_rdata_o, .frame_start_i, .pix_valid_i, .pix_r_i, .pix_g_i, .pix_b_i, .pix_y_i,
		.line_end_i, .cpix_valid_i, .cpix_c_i, .cline_end_i, .ywr_valid_o, .ywr_addr_o,
		.ywr_data_o, .ywr_bytes_o, .cwr_valid_o, .cwr_addr_o, .cwr_data_o, .cwr_bytes_o,
		.ch2_enable_o);
	rzw_mem_model rzw_mem_model_i (.clk_i, .ywr_valid_i(ywr_valid_o), .ywr_addr_i(ywr_addr_o),
		.ywr_data_i(ywr_data_o), .ywr_bytes_i(ywr_bytes_o), .cwr_valid_i(cwr_valid_o),
		.cwr_addr_i(cwr_addr_o), .cwr_data_i(cwr_data_o));
	// ****
	// Bus and pixel tasks
	// ****
	initial forever #2 clk_i = ~clk_i;
	task automatic chk(input string n, input logic [31:0] e, g);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_we_i <= 1'b1;
		@(posedge clk_i);
		reg_we_i <= 1'b0;
		@(posedge clk_i);
	endtask : wr
	task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
		reg_addr_i <= a;
		reg_re_i <= 1'b1;
		@(posedge clk_i);
		reg_re_i <= 1'b0;
		#1 chk(n, e, reg_rdata_o);
		@(posedge clk_i);
	endtask : rdchk
	task automatic plane(input logic [7:0] o, input rzw_addr_t b, s, input logic [15:0] p,
		input rzw_line_t f, w);
		wr(o, {16'h0, b[31:16]});
		wr(o + 8'h04, {16'h0, b[15:0]});
		wr(o + 8'h08, {16'h0, s[31:16]});
		wr(o + 8'h0c, {16'h0, s[15:0]});
		wr(o + 8'h10, {16'h0, p});
		wr(o + 8'h14, {19'h0, f});
		wr(o + 8'h18, {19'h0, w});
	endtask : plane
	task automatic px(input logic [7:0] y, r, g, b, input logic le, cv);
		pix_valid_i <= 1'b1;
		pix_y_i <= y;
		pix_r_i <= r;
		pix_g_i <= g;
		pix_b_i <= b;
		line_end_i <= le;
		cpix_valid_i <= cv;
		cpix_c_i <= ~y;
		cline_end_i <= le & cv;
		@(posedge clk_i);
	endtask : px
	task automatic idle();
		pix_valid_i <= 1'b0;
		line_end_i <= 1'b0;
		cpix_valid_i <= 1'b0;
		cline_end_i <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask : idle
	task automatic fstart();
		frame_start_i <= 1'b1;
		@(posedge clk_i);
		frame_start_i <= 1'b0;
		@(posedge clk_i);
	endtask : fstart
	// ****
	// Scenarios
	// ****
	task automatic t_regs();
		rdchk("luma_wrap", LS + 8'h18, 32'h1fff);
		rdchk("chroma_wrap", CS + 8'h18, 32'h1fff);
		rdchk("alpha", `RZW_OFF_ALPHA, 32'h0);
		wr(LS + 8'h10, 32'h0000ffff);
		rdchk("pitch", LS + 8'h10, 32'hffe0);
		rdchk("unmapped", 8'hfc, 32'h0);
		wr(`RZW_OFF_CH2_EN, 32'h1);
		chk("ch2", 32'h1, {31'h0, ch2_enable_o});
		$display("Test regs done.");
	endtask : t_regs
	task automatic t_ycc();
		logic [7:0] last [4];
		wr(`RZW_OFF_FMT, 32'h0);
		plane(LS, 32'h00010000, 32'h00010000, 16'h005f, 13'h0, 13'h3);
		plane(CS, 32'h00020000, 32'h00020000, 16'h0020, 13'h0, 13'h1);
		fstart();
		for (int k = 0; k < 6; k++) begin
			px(8'(k * 16), 8'h0, 8'h0, 8'h0, 1'b0, 1'b1);
			px(8'(k * 16 + 1), 8'h0, 8'h0, 8'h0, 1'b1, 1'b1);
			last[k % 4] = 8'(k * 16);
		end
		idle();
		for (int s = 0; s < 4; s++) begin
			chk("luma", {24'h0, last[s]}, rzw_mem_model_i.ymem[32'h10000 + 32'(s * 64)]);
			chk("luma1", {24'h0, last[s] + 8'h1},
				rzw_mem_model_i.ymem[32'h10001 + 32'(s * 64)]);
		end
		for (int s = 0; s < 2; s++) begin
			chk("chroma", {24'h0, ~last[s]}, rzw_mem_model_i.cmem[32'h20000 + 32'(s * 32)]);
		end
		$display("Test ycc done.");
	endtask : t_ycc
	task automatic t_rgb();
		int c0;
		wr(`RZW_OFF_FMT, 32'h1);
		wr(`RZW_OFF_RGB_WIDTH, 32'h0);
		wr(`RZW_OFF_ALPHA, 32'ha5);
		plane(LS, 32'h00030000, 32'h00030000, 16'h0040, 13'h4, 13'h8);
		c0 = rzw_mem_model_i.ccnt;
		fstart();
		rdchk("status", `RZW_OFF_STATUS, 32'h4);
		px(8'h0, 8'h11, 8'h22, 8'h33, 1'b0, 1'b1);
		px(8'h0, 8'h44, 8'h55, 8'h66, 1'b1, 1'b1);
		px(8'h0, 8'h77, 8'h88, 8'h99, 1'b1, 1'b1);
		idle();
		chk("rgb32a", 32'ha5112233, rzw_mem_model_i.ymem[32'h30000]);
		chk("rgb32b", 32'ha5445566, rzw_mem_model_i.ymem[32'h30004]);
		chk("rgb32c", 32'ha5778899, rzw_mem_model_i.ymem[32'h30008]);
		chk("bytes", 32'h4, {29'h0, rzw_mem_model_i.ybytes});
		chk("chroma_off", 32'(c0), 32'(rzw_mem_model_i.ccnt));
		wr(`RZW_OFF_RGB_WIDTH, 32'h1);
		fstart();
		px(8'h0, 8'hff, 8'h00, 8'h81, 1'b0, 1'b0);
		px(8'h0, 8'h08, 8'hfc, 8'h07, 1'b1, 1'b0);
		idle();
		chk("rgb16a", 32'h0000f810, rzw_mem_model_i.ymem[32'h30000]);
		chk("rgb16b", 32'h00000fe0, rzw_mem_model_i.ymem[32'h30002]);
		$display("Test rgb done.");
	endtask : t_rgb
	task automatic print_verdict();
		$display("Checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : print_verdict
	initial forever begin
		@(posedge clk_i);
		cyc++;
		if (cyc == 5000) begin
			fails++;
			print_verdict();
		end
	end
	initial begin
		repeat (20) @(posedge clk_i);
		srst_i <= 1'b0;
		t_regs();
		t_ycc();
		t_rgb();
		print_verdict();
	end
endmodule : rzw_writer_tb_top

//--- hw/rzw_defines.svh
// Register offsets, field positions and reset values of the resizer output writer.
`ifndef RZW_DEFINES_SVH
`define RZW_DEFINES_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define RZW_OFF_FMT        8'h00
`define RZW_OFF_RGB_WIDTH  8'h04
`define RZW_OFF_ALPHA      8'h08
`define RZW_OFF_LUMA_SET   8'h0c
`define RZW_OFF_CHROMA_SET 8'h28
`define RZW_OFF_CH2_EN     8'h44
`define RZW_OFF_STATUS     8'h48

// Offsets inside one plane set, added to the set's base.
`define RZW_SUB_BASE_H     8'h00
`define RZW_SUB_BASE_L     8'h04
`define RZW_SUB_START_H    8'h08
`define RZW_SUB_START_L    8'h0c
`define RZW_SUB_PITCH      8'h10
`define RZW_SUB_FIRST_PTR  8'h14
`define RZW_SUB_WRAP_PTR   8'h18

// ****************************************************************
// Field widths and reset values
// ****************************************************************
`define RZW_HALF_W         16
`define RZW_PTR_W          13
`define RZW_ALPHA_W        8
`define RZW_PITCH_MASK     16'hffe0
`define RZW_RST_HALF       16'h0000
`define RZW_RST_PTR        13'h0000
`define RZW_RST_WRAP       13'h1fff
`define RZW_RST_ALPHA      8'h00
`define RZW_STAT_CHROMA_LSB 16

// ****************************************************************
// Bytes per written word
// ****************************************************************
`define RZW_BYTES_1        3'h1
`define RZW_BYTES_2        3'h2
`define RZW_BYTES_4        3'h4

`endif

//--- hw/rzw_line_addr.sv
// Line address generator for one output plane.
`timescale 1ns/100ps
`include "rzw_defines.svh"

module rzw_line_addr (
	input  wire logic             clk_i,
	input  wire logic             srst_i,
	input  wire rzw_pkg::rzw_addr_t base_i,
	input  wire rzw_pkg::rzw_addr_t start_i,
	input  wire logic [15:0]      pitch_i,
	input  wire rzw_pkg::rzw_line_t first_ptr_i,
	input  wire rzw_pkg::rzw_line_t wrap_ptr_i,
	input  wire logic             rgb_i,
	input  wire logic             frame_start_i,
	input  wire logic             beat_i,
	input  wire logic [2:0]       bytes_i,
	input  wire logic             line_end_i,
	output rzw_pkg::rzw_addr_t    cur_addr_o,
	output rzw_pkg::rzw_line_t    line_idx_o
);
	import rzw_pkg::*;

	rzw_addr_t line_addr_q;
	rzw_addr_t col_q;
	rzw_line_t idx_q;
	rzw_addr_t col_d;
	rzw_addr_t step;

	assign cur_addr_o = line_addr_q + col_q;
	assign line_idx_o = idx_q;
	assign col_d      = col_q + (beat_i ? {29'h0, bytes_i} : 32'h0);
	// In RGB the pitch register is ignored and lines follow each other.
	assign step       = rgb_i ? col_d : {16'h0, pitch_i & `RZW_PITCH_MASK};

	// ****************************************************************
	// Column and line tracking
	// ****************************************************************
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			line_addr_q <= 32'h0;
			col_q       <= 32'h0;
			idx_q       <= `RZW_RST_PTR;
		end else if (frame_start_i) begin
			line_addr_q <= start_i;
			col_q       <= 32'h0;
			idx_q       <= first_ptr_i;
		end else if (line_end_i) begin
			col_q <= 32'h0;
			if (idx_q >= wrap_ptr_i) begin
				idx_q       <= `RZW_RST_PTR;
				line_addr_q <= base_i;
			end else begin
				idx_q       <= idx_q + 13'h1;
				line_addr_q <= line_addr_q + step;
			end
		end else begin
			col_q <= col_d;
		end
	end

endmodule : rzw_line_addr

//--- hw/rzw_pkg.sv
// Types shared by the resizer output writer.
package rzw_pkg;

	typedef enum logic {
		RZW_FMT_YCC,
		RZW_FMT_RGB
	} rzw_fmt_t;

	typedef enum logic {
		RZW_RGB_32,
		RZW_RGB_16
	} rzw_rgb_width_t;

	typedef logic [31:0] rzw_addr_t;
	typedef logic [12:0] rzw_line_t;

endpackage : rzw_pkg

//--- hw/rzw_writer.sv
// Output memory writer of the first resizer channel.
// Function
// - Width select 0: 32-bit alpha, red, green, blue.
// - Width select 1: 16-bit 5-6-5 RGB word.
// - Programmed alpha fills alpha byte in 32-bit.
// - Base address built from two 16-bit halves.
// - Start address built from two 16-bit halves.
// - Line address begins at start and steps by pitch at each line end.
// - Pitch low five bits forced to zero.
// - Pitch ignored while RGB output selected.
// - Index wraps to region start past end line.
// - Chroma plane has its own address set.
// - Format bit selects YCbCr or RGB output.
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/100ps
`include "rzw_defines.svh"

module rzw_writer (
	input  wire logic         clk_i,
	input  wire logic         srst_i,
	// Register port.
	input  wire logic [7:0]   reg_addr_i,
	input  wire logic [31:0]  reg_wdata_i,
	input  wire logic         reg_we_i,
	input  wire logic         reg_re_i,
	output logic [31:0]       reg_rdata_o,
	// Pixel pipeline side.
	input  wire logic         frame_start_i,
	input  wire logic         pix_valid_i,
	input  wire logic [7:0]   pix_r_i,
	input  wire logic [7:0]   pix_g_i,
	input  wire logic [7:0]   pix_b_i,
	input  wire logic [7:0]   pix_y_i,
	input  wire logic         line_end_i,
	input  wire logic         cpix_valid_i,
	input  wire logic [7:0]   cpix_c_i,
	input  wire logic         cline_end_i,
	// Memory write port, luma or RGB plane.
	output logic              ywr_valid_o,
	output rzw_pkg::rzw_addr_t ywr_addr_o,
	output logic [31:0]       ywr_data_o,
	output logic [2:0]        ywr_bytes_o,
	// Memory write port, chroma plane.
	output logic              cwr_valid_o,
	output rzw_pkg::rzw_addr_t cwr_addr_o,
	output logic [31:0]       cwr_data_o,
	output logic [2:0]        cwr_bytes_o,
	output logic              ch2_enable_o
);
	import rzw_pkg::*;

	localparam int NPLANE = 2;

	// ****************************************************************
	// Helper functions
	// ****************************************************************
	function automatic logic [7:0] set_base(input int p);
		set_base = (p == 0) ? `RZW_OFF_LUMA_SET : `RZW_OFF_CHROMA_SET;
	endfunction : set_base

	function automatic logic [31:0] pack32(input logic [7:0] a, input logic [7:0] r,
			input logic [7:0] g, input logic [7:0] b);
		pack32 = {a, r, g, b};
	endfunction : pack32

	function automatic logic [31:0] pack565(input logic [7:0] r, input logic [7:0] g,
			input logic [7:0] b);
		pack565 = {16'h0, r[7:3], g[7:2], b[7:3]};
	endfunction : pack565

	function automatic logic [31:0] zext16(input logic [15:0] v);
		zext16 = {16'h0, v};
	endfunction : zext16

	function automatic logic [31:0] zext13(input rzw_line_t v);
		zext13 = {19'h0, v};
	endfunction : zext13

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	rzw_fmt_t       fmt_q;
	rzw_rgb_width_t rgb_width_q;
	logic [7:0]     alpha_q;
	logic           ch2_en_q;
	logic [15:0]    base_h_q  [NPLANE];
	logic [15:0]    base_l_q  [NPLANE];
	logic [15:0]    start_h_q [NPLANE];
	logic [15:0]    start_l_q [NPLANE];
	logic [15:0]    pitch_q   [NPLANE];
	rzw_line_t      first_q   [NPLANE];
	rzw_line_t      wrap_q    [NPLANE];
	rzw_addr_t      cur_addr  [NPLANE];
	rzw_line_t      line_idx  [NPLANE];
	logic [31:0]    rdata_d;
	logic           rgb;

	assign rgb = (fmt_q == RZW_FMT_RGB);

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			fmt_q       <= RZW_FMT_YCC;
			rgb_width_q <= RZW_RGB_32;
			alpha_q     <= `RZW_RST_ALPHA;
			ch2_en_q    <= 1'b0;
		end else if (reg_we_i) begin
			unique case (reg_addr_i)
				`RZW_OFF_FMT: begin
					fmt_q <= rzw_fmt_t'(reg_wdata_i[0]);
				end
				`RZW_OFF_RGB_WIDTH: begin
					rgb_width_q <= rzw_rgb_width_t'(reg_wdata_i[0]);
				end
				`RZW_OFF_ALPHA: begin
					alpha_q <= reg_wdata_i[7:0];
				end
				`RZW_OFF_CH2_EN: begin
					ch2_en_q <= reg_wdata_i[0];
				end
				default: begin
				end
			endcase
		end
	end

	// Each plane keeps its own address set.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			for (int p = 0; p < NPLANE; p++) begin
				base_h_q[p]  <= `RZW_RST_HALF;
				base_l_q[p]  <= `RZW_RST_HALF;
				start_h_q[p] <= `RZW_RST_HALF;
				start_l_q[p] <= `RZW_RST_HALF;
				pitch_q[p]   <= `RZW_RST_HALF;
				first_q[p]   <= `RZW_RST_PTR;
				wrap_q[p]    <= `RZW_RST_WRAP;
			end
		end else if (reg_we_i) begin
			for (int p = 0; p < NPLANE; p++) begin
				if (reg_addr_i == set_base(p) + `RZW_SUB_BASE_H) begin
					base_h_q[p] <= reg_wdata_i[15:0];
				end
				if (reg_addr_i == set_base(p) + `RZW_SUB_BASE_L) begin
					base_l_q[p] <= reg_wdata_i[15:0];
				end
				if (reg_addr_i == set_base(p) + `RZW_SUB_START_H) begin
					start_h_q[p] <= reg_wdata_i[15:0];
				end
				if (reg_addr_i == set_base(p) + `RZW_SUB_START_L) begin
					start_l_q[p] <= reg_wdata_i[15:0];
				end
				if (reg_addr_i == set_base(p) + `RZW_SUB_PITCH) begin
					pitch_q[p] <= reg_wdata_i[15:0] & `RZW_PITCH_MASK;
				end
				if (reg_addr_i == set_base(p) + `RZW_SUB_FIRST_PTR) begin
					first_q[p] <= reg_wdata_i[12:0];
				end
				if (reg_addr_i == set_base(p) + `RZW_SUB_WRAP_PTR) begin
					wrap_q[p] <= reg_wdata_i[12:0];
				end
			end
		end
	end

	// ****************************************************************
	// Read path
	// ****************************************************************
	always_comb begin
		rdata_d = 32'h0;
		unique case (reg_addr_i)
			`RZW_OFF_FMT:       rdata_d = {31'h0, fmt_q};
			`RZW_OFF_RGB_WIDTH: rdata_d = {31'h0, rgb_width_q};
			`RZW_OFF_ALPHA:     rdata_d = {24'h0, alpha_q};
			`RZW_OFF_CH2_EN:    rdata_d = {31'h0, ch2_en_q};
			`RZW_OFF_STATUS: begin
				rdata_d = zext13(line_idx[0]) | (zext13(line_idx[1]) << `RZW_STAT_CHROMA_LSB);
			end
			default: begin
				for (int p = 0; p < NPLANE; p++) begin
					if (reg_addr_i == set_base(p) + `RZW_SUB_BASE_H) begin
						rdata_d = zext16(base_h_q[p]);
					end
					if (reg_addr_i == set_base(p) + `RZW_SUB_BASE_L) begin
						rdata_d = zext16(base_l_q[p]);
					end
					if (reg_addr_i == set_base(p) + `RZW_SUB_START_H) begin
						rdata_d = zext16(start_h_q[p]);
					end
					if (reg_addr_i == set_base(p) + `RZW_SUB_START_L) begin
						rdata_d = zext16(start_l_q[p]);
					end
					if (reg_addr_i == set_base(p) + `RZW_SUB_PITCH) begin
						rdata_d = zext16(pitch_q[p]);
					end
					if (reg_addr_i == set_base(p) + `RZW_SUB_FIRST_PTR) begin
						rdata_d = zext13(first_q[p]);
					end
					if (reg_addr_i == set_base(p) + `RZW_SUB_WRAP_PTR) begin
						rdata_d = zext13(wrap_q[p]);
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			reg_rdata_o <= 32'h0;
		end else if (reg_re_i) begin
			reg_rdata_o <= rdata_d;
		end else begin
			reg_rdata_o <= 32'h0;
		end
	end

	// ****************************************************************
	// Line address generators
	// ****************************************************************
	logic [2:0] ybytes;
	logic       ybeat;
	logic       cbeat;

	// RGB words are two or four bytes; YCbCr samples are one byte each.
	assign ybytes = !rgb ? `RZW_BYTES_1 :
		(rgb_width_q == RZW_RGB_16) ? `RZW_BYTES_2 : `RZW_BYTES_4;
	assign ybeat  = pix_valid_i && !frame_start_i;
	assign cbeat  = cpix_valid_i && !rgb && !frame_start_i;

	for (genvar p = 0; p < NPLANE; p++) begin : g_plane
		rzw_line_addr u_line (
			.clk_i         (clk_i),
			.srst_i        (srst_i),
			.base_i        ({base_h_q[p], base_l_q[p]}),
			.start_i       ({start_h_q[p], start_l_q[p]}),
			.pitch_i       (pitch_q[p]),
			.first_ptr_i   (first_q[p]),
			.wrap_ptr_i    (wrap_q[p]),
			.rgb_i         (rgb),
			.frame_start_i (frame_start_i),
			.beat_i        ((p == 0) ? ybeat : cbeat),
			.bytes_i       ((p == 0) ? ybytes : `RZW_BYTES_1),
			.line_end_i    ((p == 0) ? line_end_i : cline_end_i),
			.cur_addr_o    (cur_addr[p]),
			.line_idx_o    (line_idx[p])
		);
	end

	// ****************************************************************
	// Pixel packing and write ports
	// ****************************************************************
	logic [31:0] ydata;

	always_comb begin
		ydata = {24'h0, pix_y_i};
		if (rgb) begin
			if (rgb_width_q == RZW_RGB_16) begin
				ydata = pack565(pix_r_i, pix_g_i, pix_b_i);
			end else begin
				ydata = pack32(alpha_q, pix_r_i, pix_g_i, pix_b_i);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ywr_valid_o <= 1'b0;
			ywr_addr_o  <= 32'h0;
			ywr_data_o  <= 32'h0;
			ywr_bytes_o <= 3'h0;
		end else begin
			ywr_valid_o <= ybeat;
			if (ybeat) begin
				ywr_addr_o  <= cur_addr[0];
				ywr_data_o  <= ydata;
				ywr_bytes_o <= ybytes;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cwr_valid_o <= 1'b0;
			cwr_addr_o  <= 32'h0;
			cwr_data_o  <= 32'h0;
			cwr_bytes_o <= 3'h0;
		end else begin
			cwr_valid_o <= cbeat;
			if (cbeat) begin
				cwr_addr_o  <= cur_addr[1];
				cwr_data_o  <= {24'h0, cpix_c_i};
				cwr_bytes_o <= `RZW_BYTES_1;
			end
		end
	end

	assign ch2_enable_o = ch2_en_q;

endmodule : rzw_writer
